// ### rtl/spi_byte_engine.sv
// Serial byte engine, master or slave, behind an AHB-Lite register slave.
// Assumes single word AHB-Lite transfers and pins sampled from outside.
//
// Functional notes
// - Data register write loads transmit buffer; read returns receive buffer.
// - Master shifts eight bits MSB first, incoming bits into same register.
// - After last bit, shift register copies to receive buffer, interrupt raised.
// - An unread received byte is simply overwritten by the next one.
// - Master: write while idle moves byte to shift register and starts.
// - Write while busy waits in buffer until current byte completes.
// - Pending flag set by write until byte moves; rewrite replaces it.
// - Master emits exactly eight clock pulses per byte at selected rate.
// - Active clock phase about one third fastest, one half otherwise.
// - Slave: byte written with select high waits until select low.
// - Slave shifting waits for external clock edges; never makes clock.
// - Select high mid-byte aborts it: no done flag, no interrupt.
// - Every select falling edge reloads transmit buffer into shift register.
// - Slave shifting runs in suspend; end-of-byte interrupt wakes device.
// - Done flag set by hardware with interrupt; cleared only by writing zero.
// - Mode field: 00 off, 01 master, 10 slave, 11 reserved.
// - Polarity one idles clock high, zero idles low; slave matches master.
// - Rate field picks 2, 1, 0.5, 0.0625 Mbit/s in master only.
// - Mode off holds pin outputs at one; master drives clock and mosi, slave drives miso only while selected.
`include "spi_engine_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module spi_byte_engine (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic ss_n_i,
  // Byte done interrupt request, also the wake source
  output logic spi_irq
);
  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  spi_engine_pkg::reg_sel_e wr_sel_ff, rd_sel_ff;
  logic wr_pend_ff, rd_pend_ff, hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff;
  logic [1:0] mode_ff, rate_ff;
  logic cpol_ff, cpha_ff, done_flag_ff, pend_flag_ff;
  spi_engine_pkg::byte_t tx_buf_ff, rx_buf_ff, shift_ff, nxt_shift;
  logic samp_ff, out_bit_ff, busy_ff, sck_ff, irq_ff;
  logic [3:0] bit_cnt_ff;
  logic sck_s, ss_n_s, mosi_s, miso_s, sck_d_ff, ss_d_ff;
  logic sck_o_ff, sck_oe_ff, mosi_o_ff, mosi_oe_ff, miso_o_ff, miso_oe_ff;
  logic acc, wr_data, wr_ctrl, is_master, is_slave;
  logic m_lead, m_trail, s_lead, s_trail, lead, trail, in_bit;
  logic ss_fall, ss_rise, load_m, load_s, done;

  // Register decode of a byte address
  function automatic spi_engine_pkg::reg_sel_e reg_sel(input logic [31:0] a);
    if (a == `SPI_DATA_ADDR) begin
      reg_sel = spi_engine_pkg::SEL_DATA;
    end else if (a == `SPI_CTRL_ADDR) begin
      reg_sel = spi_engine_pkg::SEL_CTRL;
    end else begin
      reg_sel = spi_engine_pkg::SEL_NONE;
    end
  endfunction : reg_sel

  // ---------------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------------
  assign acc = hsel && htrans[1] && hready;
  assign wr_data = wr_pend_ff && wr_sel_ff == spi_engine_pkg::SEL_DATA;
  assign wr_ctrl = wr_pend_ff && wr_sel_ff == spi_engine_pkg::SEL_CTRL;

  // Writes complete with no wait state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_ff <= 1'b0;
      wr_sel_ff <= spi_engine_pkg::SEL_NONE;
    end else begin
      wr_pend_ff <= acc && hwrite;
      wr_sel_ff <= reg_sel(haddr);
    end
  end

  // Reads take one wait state so read data is current
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend_ff <= 1'b0;
      rd_sel_ff <= spi_engine_pkg::SEL_NONE;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
      if (acc && !hwrite) begin
        rd_pend_ff <= 1'b1;
        rd_sel_ff <= reg_sel(haddr);
        hreadyout_ff <= 1'b0;
      end else if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        case (rd_sel_ff)
          spi_engine_pkg::SEL_DATA: hrdata_ff <= {24'h00_0000, rx_buf_ff};
          spi_engine_pkg::SEL_CTRL: hrdata_ff <= {24'h00_0000, done_flag_ff, pend_flag_ff,
            mode_ff, cpol_ff, cpha_ff, rate_ff};
          default: hrdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control fields written by software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= `MODE_OFF;
      cpol_ff <= 1'b0;
      cpha_ff <= 1'b0;
      rate_ff <= `RATE_FAST;
    end else if (wr_ctrl) begin
      mode_ff <= hwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
      cpol_ff <= hwdata[`CTRL_CPOL_BIT];
      cpha_ff <= hwdata[`CTRL_CPHA_BIT];
      rate_ff <= hwdata[`CTRL_RATE_HI:`CTRL_RATE_LO];
    end
  end

  // Transmit buffer; a rewrite replaces the pending byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf_ff <= `SPI_DATA_RESET;
    end else if (wr_data) begin
      tx_buf_ff <= hwdata[7:0];
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------
  sync_2ff u_sync_sck (.clock(clock), .arst_n(arst_n), .din(sck_i), .dout(sck_s));
  sync_2ff u_sync_ss (.clock(clock), .arst_n(arst_n), .din(ss_n_i), .dout(ss_n_s));
  sync_2ff u_sync_mosi (.clock(clock), .arst_n(arst_n), .din(mosi_i), .dout(mosi_s));
  sync_2ff u_sync_miso (.clock(clock), .arst_n(arst_n), .din(miso_i), .dout(miso_s));

  // Previous synchronised levels
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_d_ff <= 1'b0;
      ss_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= sck_s;
      ss_d_ff <= ss_n_s;
    end
  end

  assign is_master = mode_ff == `MODE_MASTER;
  assign is_slave = mode_ff == `MODE_SLAVE;

  // Slave edges come only from the external clock while selected
  assign s_lead = is_slave && !ss_n_s && sck_d_ff == cpol_ff && sck_s != cpol_ff;
  assign s_trail = is_slave && !ss_n_s && sck_d_ff != cpol_ff && sck_s == cpol_ff;
  assign ss_fall = is_slave && ss_d_ff && !ss_n_s;
  assign ss_rise = is_slave && !ss_d_ff && ss_n_s;

  // Master edges from the rate generator
  sck_rate_gen u_rate (
    .clock(clock),
    .arst_n(arst_n),
    .run(busy_ff && is_master),
    .sel(rate_ff),
    .lead(m_lead),
    .trail(m_trail)
  );

  assign lead = is_master ? m_lead : s_lead;
  assign trail = is_master ? m_trail : s_trail;
  assign in_bit = is_master ? miso_s : mosi_s;
  assign done = trail && bit_cnt_ff == `BIT_LAST;

  // Loads from the transmit buffer
  assign load_m = is_master && !busy_ff && pend_flag_ff;
  assign load_s = is_slave && !ss_n_s && bit_cnt_ff == 4'h0 && pend_flag_ff && !lead
    && !trail;

  // Shift on trailing edge; phase picks the sampled or live bit
  assign nxt_shift = {shift_ff[6:0], cpha_ff ? in_bit : samp_ff};

  // ---------------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------------
  // Shift register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= 8'h00;
    end else if (ss_fall) begin
      shift_ff <= tx_buf_ff;
    end else if (load_m || load_s) begin
      shift_ff <= tx_buf_ff;
    end else if (trail) begin
      shift_ff <= nxt_shift;
    end
  end

  // Leading edge sample in phase zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      samp_ff <= 1'b0;
    end else if (lead && !cpha_ff) begin
      samp_ff <= in_bit;
    end
  end

  // Outgoing bit, MSB first
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_bit_ff <= 1'b1;
    end else if (ss_fall || load_m || load_s) begin
      out_bit_ff <= tx_buf_ff[7];
    end else if (lead && cpha_ff) begin
      out_bit_ff <= shift_ff[7];
    end else if (trail && !cpha_ff) begin
      out_bit_ff <= nxt_shift[7];
    end
  end

  // Bit counter; select release aborts a partial byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= 4'h0;
    end else if (!(is_master || is_slave) || ss_fall || (is_slave && ss_n_s)) begin
      bit_cnt_ff <= 4'h0;
    end else if (done) begin
      bit_cnt_ff <= 4'h0;
    end else if (trail) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // Master busy from load to the eighth trailing edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
    end else if (!is_master || done) begin
      busy_ff <= 1'b0;
    end else if (load_m) begin
      busy_ff <= 1'b1;
    end
  end

  // Master clock level: idles at polarity
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_ff <= 1'b0;
    end else if (!busy_ff || trail) begin
      sck_ff <= cpol_ff;
    end else if (lead) begin
      sck_ff <= !cpol_ff;
    end
  end

  // Receive buffer overwritten on every completed byte
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_ff <= `SPI_DATA_RESET;
    end else if (done) begin
      rx_buf_ff <= nxt_shift;
    end
  end

  // Pending flag; a new write wins over the move
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_flag_ff <= 1'b0;
    end else if (wr_data) begin
      pend_flag_ff <= 1'b1;
    end else if (load_m || load_s || ss_fall) begin
      pend_flag_ff <= 1'b0;
    end
  end

  // Done flag and interrupt; setting wins over a clearing write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      done_flag_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= done;
      if (done) begin
        done_flag_ff <= 1'b1;
      end else if (wr_ctrl && !hwdata[`CTRL_DONE_BIT]) begin
        done_flag_ff <= 1'b0;
      end
    end
  end

  // Pin drive; idle pins sit at one for port use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sck_o_ff <= 1'b1;
      sck_oe_ff <= 1'b0;
      mosi_o_ff <= 1'b1;
      mosi_oe_ff <= 1'b0;
      miso_o_ff <= 1'b1;
      miso_oe_ff <= 1'b0;
    end else begin
      sck_o_ff <= is_master ? sck_ff : 1'b1;
      sck_oe_ff <= is_master;
      mosi_o_ff <= is_master ? out_bit_ff : 1'b1;
      mosi_oe_ff <= is_master;
      miso_o_ff <= is_slave ? out_bit_ff : 1'b1;
      miso_oe_ff <= is_slave && !ss_n_s;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign sck_o = sck_o_ff;
  assign sck_oe = sck_oe_ff;
  assign mosi_o = mosi_o_ff;
  assign mosi_oe = mosi_oe_ff;
  assign miso_o = miso_o_ff;
  assign miso_oe = miso_oe_ff;
  assign spi_irq = irq_ff;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  // Leading edges seen on the master clock output since load
  logic [3:0] lead_seen_ff;
  logic sck_q_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lead_seen_ff <= 4'h0;
      sck_q_ff <= 1'b0;
    end else begin
      sck_q_ff <= sck_ff;
      if (load_m) begin
        lead_seen_ff <= 4'h0;
      end else if (busy_ff && sck_ff != cpol_ff && sck_q_ff == cpol_ff) begin
        lead_seen_ff <= lead_seen_ff + 4'h1;
      end
    end
  end

  sequence s_master_load;
    load_m ##1 busy_ff;
  endsequence

  property p_rx_readback;
    rd_pend_ff && rd_sel_ff == spi_engine_pkg::SEL_DATA
      |=> hreadyout_ff && hrdata_ff[7:0] == $past(rx_buf_ff);
  endproperty
  a_rx_readback: assert property (p_rx_readback) else $error("read not receive buffer");

  property p_msb_first;
    s_master_load |-> out_bit_ff == $past(tx_buf_ff[7], 1);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not MSB");

  property p_done_capture;
    done |=> rx_buf_ff == $past(nxt_shift) && done_flag_ff && spi_irq;
  endproperty
  a_done_capture: assert property (p_done_capture) else $error("byte end not captured");

  property p_master_start;
    load_m |=> busy_ff && shift_ff == $past(tx_buf_ff) && pend_flag_ff == $past(wr_data);
  endproperty
  a_master_start: assert property (p_master_start) else $error("idle load did not start");

  property p_hold_pending;
    is_master && busy_ff && pend_flag_ff && !done && !wr_ctrl |=> pend_flag_ff;
  endproperty
  a_hold_pending: assert property (p_hold_pending) else $error("pending byte lost");

  property p_pend_set;
    wr_data |=> pend_flag_ff && tx_buf_ff == $past(hwdata[7:0]);
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("write did not set pending");

  property p_eight_pulses;
    done && is_master |-> lead_seen_ff == `BITS_PER_BYTE;
  endproperty
  a_eight_pulses: assert property (p_eight_pulses) else $error("not eight clock pulses");

  property p_slave_wait;
    is_slave && ss_n_s && pend_flag_ff && !wr_ctrl |=> pend_flag_ff;
  endproperty
  a_slave_wait: assert property (p_slave_wait) else $error("byte moved while deselected");

  property p_abort;
    ss_rise && bit_cnt_ff != 4'h0 |=> bit_cnt_ff == 4'h0 && !spi_irq ##1 !spi_irq;
  endproperty
  a_abort: assert property (p_abort) else $error("aborted byte completed");

  property p_reload;
    ss_fall |=> shift_ff == $past(tx_buf_ff);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on select");

  property p_done_sticky;
    done_flag_ff && !(wr_ctrl && !hwdata[`CTRL_DONE_BIT]) |=> done_flag_ff;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

  property p_disabled;
    !is_master && !is_slave |=> !sck_oe && !mosi_oe && !miso_oe && mosi_o && sck_o && !spi_irq;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled block drives pins");
endmodule : spi_byte_engine
`default_nettype wire

// ### rtl/spi_engine_consts.svh
// Constants for the serial byte engine: offsets, fields, resets, timing.
// Assumes inclusion by bare name from files under rtl/.
`ifndef SPI_ENGINE_CONSTS_SVH
`define SPI_ENGINE_CONSTS_SVH

// -----------------------------------------------------------------------
// Register map (byte address is four times the register index)
// -----------------------------------------------------------------------
`define SPI_DATA_IDX 8'h60
`define SPI_CTRL_IDX 8'h61
`define SPI_DATA_ADDR 32'h0000_0180
`define SPI_CTRL_ADDR 32'h0000_0184
`define SPI_DATA_RESET 8'h00
`define SPI_CTRL_RESET 8'h00

// -----------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------
`define CTRL_DONE_BIT 7
`define CTRL_PEND_BIT 6
`define CTRL_MODE_HI 5
`define CTRL_MODE_LO 4
`define CTRL_CPOL_BIT 3
`define CTRL_CPHA_BIT 2
`define CTRL_RATE_HI 1
`define CTRL_RATE_LO 0
`define MODE_OFF 2'h0
`define MODE_MASTER 2'h1
`define MODE_SLAVE 2'h2
`define RATE_FAST 2'h0
`define RATE_1M 2'h1

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define SYS_CLK_HZ 100_000_000
`define RATE0_BPS 2_000_000
`define RATE1_BPS 1_000_000
`define RATE2_BPS 500_000
`define RATE3_BPS 62_500
`define FAST_HIGH_PCT 33
`define SLOW_HIGH_PCT 50
`define PCT_SCALE 100
`define BIT_LAST 4'h7
`define BITS_PER_BYTE 4'h8

`endif

// ### rtl/spi_engine_pkg.sv
// Types shared by the serial byte engine files.
// Assumes nothing beyond a SystemVerilog compiler.
package spi_engine_pkg;
  // Register decode result
  typedef enum logic [1:0] {SEL_NONE, SEL_DATA, SEL_CTRL} reg_sel_e;
  typedef logic [7:0] byte_t;
endpackage : spi_engine_pkg

// ### rtl/sync_2ff.sv
// Two flip-flop synchroniser for one pin level.
// Assumes an asynchronous pin input and the block clock.
`timescale 1ns/1ns
`default_nettype none
module sync_2ff (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Level in and out
  input wire logic din,
  output logic dout
);
  logic meta_ff;

  // First stage is read only by the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule : sync_2ff
`default_nettype wire

// ### rtl/sck_rate_gen.sv
// Master serial clock edge generator: leading and trailing edge pulses.
// Assumes run is held high for the whole byte and sel stays stable.
`include "spi_engine_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module sck_rate_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Edge pulses
  output logic lead,
  output logic trail
);
  logic [10:0] cnt_ff;
  logic [10:0] period;
  logic [10:0] low_len;

  // Cycles per bit for a rate code
  function automatic logic [10:0] period_of(input logic [1:0] s);
    case (s)
      2'h0: period_of = 11'(`SYS_CLK_HZ / `RATE0_BPS);
      2'h1: period_of = 11'(`SYS_CLK_HZ / `RATE1_BPS);
      2'h2: period_of = 11'(`SYS_CLK_HZ / `RATE2_BPS);
      default: period_of = 11'(`SYS_CLK_HZ / `RATE3_BPS);
    endcase
  endfunction : period_of

  // Active (non-idle) cycles per bit; about a third at the fastest rate
  function automatic logic [10:0] high_of(input logic [1:0] s);
    if (s == `RATE_FAST) begin
      high_of = 11'(`SYS_CLK_HZ / `RATE0_BPS * `FAST_HIGH_PCT / `PCT_SCALE);
    end else begin
      high_of = 11'(32'(period_of(s)) * `SLOW_HIGH_PCT / `PCT_SCALE);
    end
  endfunction : high_of

  assign period = period_of(sel);
  assign low_len = period - high_of(sel);

  // Bit period counter, cleared while stopped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 11'h000;
    end else if (!run || cnt_ff == period - 11'h001) begin
      cnt_ff <= 11'h000;
    end else begin
      cnt_ff <= cnt_ff + 11'h001;
    end
  end

  assign lead = run && (cnt_ff == low_len - 11'h001);
  assign trail = run && (cnt_ff == period - 11'h001);

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_fast_ratio;
    lead && sel == `RATE_FAST |-> ##16 (trail || !run);
  endproperty
  a_fast_ratio: assert property (p_fast_ratio) else $error("fast active phase not 16");

  property p_mid_ratio;
    lead && sel == `RATE_1M |-> ##50 (trail || !run);
  endproperty
  a_mid_ratio: assert property (p_mid_ratio) else $error("1M active phase not 50");
endmodule : sck_rate_gen
`default_nettype wire

// ### verification/spi_far_model.sv
// Far side of the serial link: a slave for master runs, a master for slave runs.
// Assumes the bench sets cpol and cpha to match the design and drives sel_n.
`timescale 1ns/1ns
`default_nettype none
module spi_far_model (
  // Design pins watched
  input wire logic sck_o,
  input wire logic mosi_o,
  input wire logic miso_o,
  // Settings and select from the bench
  input wire logic cpol,
  input wire logic cpha,
  input wire logic sel_n,
  // Pins driven into the design
  output logic sck_i,
  output logic mosi_i,
  output logic miso_i,
  output logic ss_n_i
);
  logic [15:0] tx;
  logic [7:0] rx;
  // Idle levels, select released
  initial begin
    {ss_n_i, sck_i, mosi_i, miso_i} = 4'h8;
    tx = 16'h0;
    rx = 8'h0;
  end
  // Slave role: sample on one edge, shift on the other
  always @(sck_o) if (!sel_n) begin
    if (sck_o ^ cpol ^ cpha) rx = {rx[6:0], mosi_o};
    else if (cpha) begin
      miso_i = tx[15];
      tx = tx << 1;
    end else begin
      tx = tx << 1;
      miso_i = tx[15];
    end
  end
  // Released data line turns to the inverse
  always @(posedge sel_n) miso_i = ~miso_i;
  // Two bytes queued for the slave role
  task automatic load(input logic [15:0] b);
    tx = b;
    miso_i = b[15];
  endtask : load
  // Master role: 125 ns link clock, nb bits, then select released
  task automatic run_master(input logic [7:0] b, input int nb);
    tx = {b, 8'h00};
    sck_i = cpol;
    #100 ss_n_i = 1'b0;
    mosi_i = b[7];
    #200;
    for (int i = 0; i < nb; i++) begin
      #62 sck_i = ~cpol;
      if (cpha) begin
        mosi_i = tx[15];
        tx = tx << 1;
      end else rx = {rx[6:0], miso_o};
      #63 sck_i = cpol;
      if (cpha) rx = {rx[6:0], miso_o};
      else begin
        tx = tx << 1;
        mosi_i = tx[15];
      end
    end
    #200 ss_n_i = 1'b1;
    mosi_i = ~mosi_i;
  endtask : run_master
endmodule : spi_far_model
`default_nettype wire

// ### verification/spi_master_slave_byte_engine_bench.sv
// Self-checking bench for the serial byte engine, master and slave.
// Assumes the far side model and a 100 MHz clock.
`include "spi_engine_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_byte_engine_bench;
  logic clock, arst_n, hsel, hwrite, sel_n, cpol, cpha;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rdat;
  logic [7:0] a, c, s1, s2;
  wire logic hreadyout, hresp, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, spi_irq;
  wire logic sck_i, mosi_i, miso_i, ss_n_i;
  wire logic [31:0] hrdata;
  int n_fail, tests_run, cyc, n_irq, n_sck;
  localparam logic [31:0] da = `SPI_DATA_ADDR;
  localparam logic [31:0] ca = `SPI_CTRL_ADDR;
  spi_byte_engine dut (.clock, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .sck_i, .sck_o, .sck_oe, .mosi_i,
    .mosi_o, .mosi_oe, .miso_i, .miso_o, .miso_oe, .ss_n_i, .spi_irq);
  spi_far_model far (.sck_o, .mosi_o, .miso_o, .cpol, .cpha, .sel_n, .sck_i, .mosi_i,
    .miso_i, .ss_n_i);
  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Cycle ceiling, interrupt and clock pulse counts
  always @(posedge clock) begin
    cyc++;
    if (spi_irq === 1'b1) n_irq++;
    if (cyc == 80000) begin
      n_fail++;
      wrap_up();
    end
  end
  always @(posedge sck_o) if (!sel_n) n_sck++;
  // Expected control byte: flags are done, pending
  function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] r,
    input logic [1:0] fl);
    return {fl, m, cpol, cpha, r};
  endfunction : ctl
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One single AHB-Lite transfer, waits on hready
  task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] ad, input logic [7:0] d);
    bus(1'b1, ad, {24'h0, d});
  endtask : wr
  task automatic rchk(input logic [31:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 32'h0);
    chk(rdat[7:0], e);
  endtask : rchk
  task automatic wait_done;
    rdat = 32'h0;
    while (rdat[7] !== 1'b1) bus(1'b0, ca, 32'h0);
  endtask : wait_done
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, cpol, cpha, arst_n} = 0;
    sel_n = 1'b1;
    hsize = 3'h2;
    void'($urandom(99755));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rchk(da, 8'h00);
    rchk(ca, 8'h00);
    rchk(32'h0000_0188, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    // Master: every rate, queued and replaced bytes
    for (int r = 0; r < 4; r++) begin
      {a, c, s1, s2} = $urandom;
      {cpol, cpha} = 2'($urandom);
      wr(ca, ctl(2'h1, 2'(r), 2'h0));
      // Clock pin settles at its new idle level before the far side is selected
      repeat (4) @(posedge clock);
      far.load({s1, s2});
      sel_n <= 1'b0;
      wr(da, a);
      wr(da, ~c);
      wr(da, c);
      rchk(ca, ctl(2'h1, 2'(r), 2'h1));
      chk({5'h0, sck_oe, mosi_oe, miso_oe}, 8'h06);
      wait_done();
      rchk(da, s1);
      wr(ca, ctl(2'h1, 2'(r), 2'h0));
      rchk(ca, ctl(2'h1, 2'(r), 2'h0));
      wait_done();
      rchk(da, s2);
      chk(far.rx, c);
      sel_n <= 1'b1;
    end
    chk(8'(n_sck), 8'h40);
    // Slave: byte waits for select, full byte then aborted byte
    {cpol, cpha} = 2'($urandom);
    {a, s1, s2} = 24'($urandom);
    wr(ca, ctl(2'h2, 2'h3, 2'h0));
    wr(da, a);
    rchk(ca, ctl(2'h2, 2'h3, 2'h1));
    chk({6'h0, miso_oe, sck_oe}, 8'h00);
    far.run_master(s1, 8);
    @(posedge clock);
    rchk(ca, ctl(2'h2, 2'h3, 2'h2));
    rchk(da, s1);
    chk(far.rx, a);
    wr(ca, ctl(2'h2, 2'h3, 2'h0));
    far.run_master(s2, 5);
    @(posedge clock);
    rchk(ca, ctl(2'h2, 2'h3, 2'h0));
    // Reserved mode keeps pins idle; both checks land before off takes effect
    wr(ca, 8'h30);
    wr(da, c);
    repeat (50) @(posedge clock);
    chk({6'h0, sck_o, sck_oe}, 8'h02);
    wr(ca, 8'h00);
    chk({6'h0, mosi_o, mosi_oe}, 8'h02);
    chk(8'(n_irq), 8'h09);
    wrap_up();
  end
endmodule : spi_master_slave_byte_engine_bench
`default_nettype wire
